// >>> design/secure_partition_pkg.sv
package secure_partition_pkg;

    // Register byte addresses
    localparam logic [31:0] ETH_SEC_ADDR = 32'hF800_0450;
    localparam logic [31:0] SD_SEC_ADDR = 32'hF800_0454;
    localparam logic [31:0] USB_SEC_ADDR = 32'hF800_0458;
    localparam logic [31:0] LM_DIS_ADDR = 32'hF800_0484;
    localparam logic [31:0] HP_DIS_ADDR = 32'hF800_0488;
    localparam logic [31:0] GP_A_FILT_ADDR = 32'hF890_001C;
    localparam logic [31:0] GP_B_FILT_ADDR = 32'hF890_0020;
    localparam logic [31:0] APB_FORCE_ADDR = 32'hF890_0028;
    localparam logic [31:0] LAUNCH_STAT_ADDR = 32'hF890_0040;

    // Field positions
    localparam int PAIR_A_BIT = 0;
    localparam int PAIR_B_BIT = 1;
    localparam int HP_A_BIT = 0;
    localparam int HP_B_BIT = 1;
    localparam int HP_C_BIT = 2;
    localparam int HP_D_BIT = 3;
    localparam int TIMER_B_BIT = 4;
    localparam int MEMCTL_BIT = 5;
    localparam int FILT_BIT = 0;
    localparam int STAT_BOOT_NS_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_LAUNCHED_BIT = 2;
    localparam int STAT_ABORT_BIT = 3;
    localparam int STAT_REJECT_BIT = 4;
    localparam int STAT_CHAN_NS_BIT = 5;
    localparam int STAT_CHAN_LSB = 8;

    localparam logic [31:0] INSN_BYTES = 32'h0000_0004;
    localparam logic [1:0] BOOT_SETTLE = 2'h2;

    typedef struct packed {
        logic mac_b_nonsecure;
        logic mac_a_nonsecure;
        logic sd_ctrl_b_nonsecure;
        logic sd_ctrl_a_nonsecure;
        logic usb_ctrl_b_nonsecure;
        logic usb_ctrl_a_nonsecure;
        logic logic_master_b_ns_only;
        logic logic_master_a_ns_only;
        logic hp_port_d_ns_only;
        logic hp_port_c_ns_only;
        logic hp_port_b_ns_only;
        logic hp_port_a_ns_only;
        logic memctl_cfg_ns;
        logic timer_b_cfg_ns;
        logic hp_d_cfg_ns;
        logic hp_c_cfg_ns;
        logic hp_b_cfg_ns;
        logic hp_a_cfg_ns;
    } sec_cfg_t;

    localparam sec_cfg_t CFG_RESET = '0;

    typedef struct packed {
        logic [7:0] chan;
        logic [31:0] addr;
        logic want_ns;
        logic via_secure_port;
        logic cpu_ns;
    } go_req_t;

    typedef enum logic [2:0] {
        ST_BOOT = 3'b001,
        ST_IDLE = 3'b010,
        ST_FETCH = 3'b100
    } launch_state_t;

endpackage : secure_partition_pkg

// >>> design/insn_cache_mem.sv
`timescale 1ns/1ns
module insn_cache_mem
    import secure_partition_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // Clock
    input wire logic clk_in,
    // Write side
    input wire logic wr_en_in,
    input wire logic [$clog2(DEPTH)-1:0] wr_idx_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    // Read side
    input wire logic rd_en_in,
    input wire logic [$clog2(DEPTH)-1:0] rd_idx_in,
    output logic [WIDTH-1:0] rd_data_out
);

    logic [WIDTH-1:0] mem_q [DEPTH];

    if (DEPTH < 2 || WIDTH < 1) begin : g_chk
        $error("insn_cache_mem: DEPTH must be at least 2");
    end

    // No reset on the array; contents are only trusted after a fetch
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_q[wr_idx_in] <= wr_data_in;
        end
        if (rd_en_in) begin
            rd_data_out <= mem_q[rd_idx_in];
        end
    end

endmodule : insn_cache_mem

// >>> design/go_permission.sv
`timescale 1ns/1ns
module go_permission
    import secure_partition_pkg::*;
(
    // Launch context
    input wire logic dma_ns_in,
    input wire logic via_secure_port_in,
    input wire logic cpu_ns_in,
    input wire logic want_ns_in,
    // Decision
    output logic allow_out,
    output logic chan_ns_out
);

    always_comb begin
        allow_out = 1'b1;
        if (cpu_ns_in && via_secure_port_in) begin
            allow_out = 1'b0;
        end
        if (!dma_ns_in && !via_secure_port_in) begin
            allow_out = 1'b0;
        end
        if (dma_ns_in && !want_ns_in) begin
            allow_out = 1'b0;
        end
        // Non-secure controller only ever runs non-secure channels
        chan_ns_out = dma_ns_in | want_ns_in;
    end

endmodule : go_permission

// >>> design/security_partition_config.sv
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
module security_partition_config
    import secure_partition_pkg::*;
#(
    parameter int NUM_CHANNELS = 8,
    parameter int FETCH_WORDS = 8
) (
    // Clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    // APB slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [31:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic PREADY_OUT,
    output logic [31:0] PRDATA_OUT,
    output logic PSLVERR_OUT,
    // Security sideband
    output sec_cfg_t SEC_CFG_OUT,
    // Master port attribute forcing
    input wire logic [1:0] LM_REQ_NS_IN,
    output logic [1:0] LM_REQ_NS_OUT,
    input wire logic [3:0] HP_REQ_NS_IN,
    output logic [3:0] HP_REQ_NS_OUT,
    // General-purpose filter settings (asynchronous) and request gating
    input wire logic GP_A_NS_PASS_IN,
    input wire logic GP_B_NS_PASS_IN,
    input wire logic [1:0] GP_REQ_VALID_IN,
    input wire logic [1:0] GP_REQ_NS_IN,
    output logic [1:0] GP_REQ_PASS_OUT,
    // DMA boot security strap (asynchronous)
    input wire logic DMA_BOOT_NS_IN,
    // Channel launch
    input wire logic GO_VALID_IN,
    input go_req_t GO_REQ_IN,
    output logic GO_READY_OUT,
    output logic LAUNCH_OK_OUT,
    output logic LAUNCH_FAIL_OUT,
    // Instruction fetch
    output logic FETCH_REQ_OUT,
    output logic [31:0] FETCH_ADDR_OUT,
    output logic FETCH_NS_OUT,
    input wire logic FETCH_ACK_IN,
    input wire logic FETCH_ABORT_IN,
    input wire logic [31:0] FETCH_DATA_IN,
    // Instruction cache read
    input wire logic CACHE_RD_EN_IN,
    input wire logic [$clog2(FETCH_WORDS)-1:0] CACHE_RD_IDX_IN,
    output logic [31:0] CACHE_RD_DATA_OUT
);

    localparam int CH_W = $clog2(NUM_CHANNELS);
    localparam int IDX_W = $clog2(FETCH_WORDS);
    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(FETCH_WORDS - 1);
    localparam logic [7:0] CHAN_LIMIT = 8'(NUM_CHANNELS - 1);

    if (NUM_CHANNELS < 2 || NUM_CHANNELS > 256 || FETCH_WORDS < 2) begin : g_chk
        $error("security_partition_config: unsupported channel or fetch depth");
    end

    typedef struct packed {
        sec_cfg_t cfg;
        logic [1:0] gp_sync1;
        logic [1:0] gp_sync2;
        logic boot_sync1;
        logic boot_sync2;
        logic dma_ns;
        logic [1:0] settle;
        launch_state_t st;
        logic [CH_W-1:0] chan;
        logic chan_ns;
        logic [31:0] fetch_addr;
        logic [IDX_W-1:0] widx;
        logic launched;
        logic abort_flag;
        logic reject_flag;
        logic ok_pulse;
        logic fail_pulse;
        logic [31:0] prdata;
        logic pslverr;
    } state_t;

    state_t q;
    state_t d;
    logic go_allow;
    logic go_chan_ns;
    logic cache_we;
    logic setup;
    logic wr_access;

    go_permission u_go_permission (
        .dma_ns_in(q.dma_ns),
        .via_secure_port_in(GO_REQ_IN.via_secure_port),
        .cpu_ns_in(GO_REQ_IN.cpu_ns),
        .want_ns_in(GO_REQ_IN.want_ns),
        .allow_out(go_allow),
        .chan_ns_out(go_chan_ns)
    );

    insn_cache_mem #(
        .WIDTH(32),
        .DEPTH(FETCH_WORDS)
    ) u_insn_cache_mem (
        .clk_in(REF_CLK_IN),
        .wr_en_in(cache_we),
        .wr_idx_in(q.widx),
        .wr_data_in(FETCH_DATA_IN),
        .rd_en_in(CACHE_RD_EN_IN),
        .rd_idx_in(CACHE_RD_IDX_IN),
        .rd_data_out(CACHE_RD_DATA_OUT)
    );

    assign setup = PSEL_IN & ~PENABLE_IN;
    assign wr_access = PSEL_IN & PENABLE_IN & PWRITE_IN;

    always_comb begin
        d = q;
        cache_we = 1'b0;
        d.ok_pulse = 1'b0;
        d.fail_pulse = 1'b0;
        d.gp_sync1 = {GP_B_NS_PASS_IN, GP_A_NS_PASS_IN};
        d.gp_sync2 = q.gp_sync1;
        d.boot_sync1 = DMA_BOOT_NS_IN;
        d.boot_sync2 = q.boot_sync1;

        // Read data captured in setup so access phase can finish at once
        if (setup) begin
            d.prdata = '0;
            d.pslverr = 1'b0;
            case (PADDR_IN)
                ETH_SEC_ADDR: begin
                    d.prdata[PAIR_B_BIT] = q.cfg.mac_b_nonsecure;
                    d.prdata[PAIR_A_BIT] = q.cfg.mac_a_nonsecure;
                end
                SD_SEC_ADDR: begin
                    d.prdata[PAIR_B_BIT] = q.cfg.sd_ctrl_b_nonsecure;
                    d.prdata[PAIR_A_BIT] = q.cfg.sd_ctrl_a_nonsecure;
                end
                USB_SEC_ADDR: begin
                    d.prdata[PAIR_B_BIT] = q.cfg.usb_ctrl_b_nonsecure;
                    d.prdata[PAIR_A_BIT] = q.cfg.usb_ctrl_a_nonsecure;
                end
                LM_DIS_ADDR: begin
                    d.prdata[PAIR_B_BIT] = q.cfg.logic_master_b_ns_only;
                    d.prdata[PAIR_A_BIT] = q.cfg.logic_master_a_ns_only;
                end
                HP_DIS_ADDR: begin
                    d.prdata[HP_D_BIT] = q.cfg.hp_port_d_ns_only;
                    d.prdata[HP_C_BIT] = q.cfg.hp_port_c_ns_only;
                    d.prdata[HP_B_BIT] = q.cfg.hp_port_b_ns_only;
                    d.prdata[HP_A_BIT] = q.cfg.hp_port_a_ns_only;
                end
                GP_A_FILT_ADDR: begin
                    d.prdata[FILT_BIT] = q.gp_sync2[0];
                end
                GP_B_FILT_ADDR: begin
                    d.prdata[FILT_BIT] = q.gp_sync2[1];
                end
                APB_FORCE_ADDR: begin
                    d.prdata[MEMCTL_BIT] = q.cfg.memctl_cfg_ns;
                    d.prdata[TIMER_B_BIT] = q.cfg.timer_b_cfg_ns;
                    d.prdata[HP_D_BIT] = q.cfg.hp_d_cfg_ns;
                    d.prdata[HP_C_BIT] = q.cfg.hp_c_cfg_ns;
                    d.prdata[HP_B_BIT] = q.cfg.hp_b_cfg_ns;
                    d.prdata[HP_A_BIT] = q.cfg.hp_a_cfg_ns;
                end
                LAUNCH_STAT_ADDR: begin
                    d.prdata[STAT_BOOT_NS_BIT] = q.dma_ns;
                    d.prdata[STAT_BUSY_BIT] = (q.st != ST_IDLE);
                    d.prdata[STAT_LAUNCHED_BIT] = q.launched;
                    d.prdata[STAT_ABORT_BIT] = q.abort_flag;
                    d.prdata[STAT_REJECT_BIT] = q.reject_flag;
                    d.prdata[STAT_CHAN_NS_BIT] = q.chan_ns;
                    d.prdata[STAT_CHAN_LSB +: CH_W] = q.chan;
                end
                default: begin
                    d.pslverr = 1'b1;
                end
            endcase
        end

        // Reserved bits are dropped on write and read back as zero
        if (wr_access) begin
            case (PADDR_IN)
                ETH_SEC_ADDR: begin
                    d.cfg.mac_b_nonsecure = PWDATA_IN[PAIR_B_BIT];
                    d.cfg.mac_a_nonsecure = PWDATA_IN[PAIR_A_BIT];
                end
                SD_SEC_ADDR: begin
                    d.cfg.sd_ctrl_b_nonsecure = PWDATA_IN[PAIR_B_BIT];
                    d.cfg.sd_ctrl_a_nonsecure = PWDATA_IN[PAIR_A_BIT];
                end
                USB_SEC_ADDR: begin
                    d.cfg.usb_ctrl_b_nonsecure = PWDATA_IN[PAIR_B_BIT];
                    d.cfg.usb_ctrl_a_nonsecure = PWDATA_IN[PAIR_A_BIT];
                end
                LM_DIS_ADDR: begin
                    d.cfg.logic_master_b_ns_only = PWDATA_IN[PAIR_B_BIT];
                    d.cfg.logic_master_a_ns_only = PWDATA_IN[PAIR_A_BIT];
                end
                HP_DIS_ADDR: begin
                    d.cfg.hp_port_d_ns_only = PWDATA_IN[HP_D_BIT];
                    d.cfg.hp_port_c_ns_only = PWDATA_IN[HP_C_BIT];
                    d.cfg.hp_port_b_ns_only = PWDATA_IN[HP_B_BIT];
                    d.cfg.hp_port_a_ns_only = PWDATA_IN[HP_A_BIT];
                end
                APB_FORCE_ADDR: begin
                    d.cfg.memctl_cfg_ns = PWDATA_IN[MEMCTL_BIT];
                    d.cfg.timer_b_cfg_ns = PWDATA_IN[TIMER_B_BIT];
                    d.cfg.hp_d_cfg_ns = PWDATA_IN[HP_D_BIT];
                    d.cfg.hp_c_cfg_ns = PWDATA_IN[HP_C_BIT];
                    d.cfg.hp_b_cfg_ns = PWDATA_IN[HP_B_BIT];
                    d.cfg.hp_a_cfg_ns = PWDATA_IN[HP_A_BIT];
                end
                // Write one clears; the FSM below runs later so a set wins
                LAUNCH_STAT_ADDR: begin
                    if (PWDATA_IN[STAT_ABORT_BIT]) begin
                        d.abort_flag = 1'b0;
                    end
                    if (PWDATA_IN[STAT_REJECT_BIT]) begin
                        d.reject_flag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        case (q.st)
            // security state sampled once synchroniser has settled
            ST_BOOT: begin
                d.settle = q.settle + 2'h1;
                if (q.settle == BOOT_SETTLE) begin
                    d.dma_ns = q.boot_sync2;
                    d.st = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (GO_VALID_IN) begin
                    if (go_allow && GO_REQ_IN.chan <= CHAN_LIMIT) begin
                        d.chan = CH_W'(GO_REQ_IN.chan);
                        d.chan_ns = go_chan_ns;
                        d.fetch_addr = GO_REQ_IN.addr;
                        d.widx = '0;
                        d.launched = 1'b0;
                        d.st = ST_FETCH;
                    end else begin
                        d.reject_flag = 1'b1;
                        d.fail_pulse = 1'b1;
                    end
                end
            end
            ST_FETCH: begin
                if (FETCH_ABORT_IN) begin
                    d.abort_flag = 1'b1;
                    d.fail_pulse = 1'b1;
                    d.st = ST_IDLE;
                end else if (FETCH_ACK_IN) begin
                    cache_we = 1'b1;
                    d.fetch_addr = q.fetch_addr + INSN_BYTES;
                    d.widx = q.widx + 1'b1;
                    if (q.widx == LAST_IDX) begin
                        d.launched = 1'b1;
                        d.ok_pulse = 1'b1;
                        d.st = ST_IDLE;
                    end
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            q <= '0;
            q.cfg <= CFG_RESET;
            q.st <= ST_BOOT;
        end else begin
            q <= d;
        end
    end

    assign PREADY_OUT = 1'b1;
    assign PRDATA_OUT = q.prdata;
    assign PSLVERR_OUT = q.pslverr & PSEL_IN & PENABLE_IN;
    assign SEC_CFG_OUT = q.cfg;
    assign LM_REQ_NS_OUT = LM_REQ_NS_IN
        | {q.cfg.logic_master_b_ns_only, q.cfg.logic_master_a_ns_only};
    assign HP_REQ_NS_OUT = HP_REQ_NS_IN
        | {q.cfg.hp_port_d_ns_only, q.cfg.hp_port_c_ns_only,
           q.cfg.hp_port_b_ns_only, q.cfg.hp_port_a_ns_only};
    assign GP_REQ_PASS_OUT = GP_REQ_VALID_IN & (~GP_REQ_NS_IN | q.gp_sync2);
    assign GO_READY_OUT = (q.st == ST_IDLE);
    assign LAUNCH_OK_OUT = q.ok_pulse;
    assign LAUNCH_FAIL_OUT = q.fail_pulse;
    assign FETCH_REQ_OUT = (q.st == ST_FETCH);
    assign FETCH_ADDR_OUT = q.fetch_addr;
    assign FETCH_NS_OUT = q.chan_ns;

endmodule : security_partition_config

// >>> dv/security_partition_config_properties.sv
`timescale 1ns/1ns
module security_partition_config_checker
    import secure_partition_pkg::*;
#(
    parameter int NUM_CHANNELS = 8,
    parameter int FETCH_WORDS = 8
) (
    // Clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    // APB
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [31:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    // Sideband and forcing
    input wire sec_cfg_t SEC_CFG_OUT,
    input wire logic [1:0] LM_REQ_NS_IN,
    input wire logic [1:0] LM_REQ_NS_OUT,
    input wire logic [3:0] HP_REQ_NS_IN,
    input wire logic [3:0] HP_REQ_NS_OUT,
    input wire logic [1:0] GP_REQ_VALID_IN,
    input wire logic [1:0] GP_REQ_NS_IN,
    input wire logic [1:0] GP_REQ_PASS_OUT,
    // Launch and fetch
    input wire logic GO_VALID_IN,
    input wire go_req_t GO_REQ_IN,
    input wire logic GO_READY_OUT,
    input wire logic LAUNCH_FAIL_OUT,
    input wire logic FETCH_REQ_OUT,
    input wire logic [31:0] FETCH_ADDR_OUT,
    input wire logic FETCH_ACK_IN,
    input wire logic FETCH_ABORT_IN
);
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (RST_IN);
    logic wr_acc;
    assign wr_acc = PSEL_IN && PENABLE_IN && PWRITE_IN;
    sequence go_taken;
        GO_VALID_IN && GO_READY_OUT;
    endsequence
    sequence fetch_wait;
        FETCH_REQ_OUT && !FETCH_ACK_IN && !FETCH_ABORT_IN;
    endsequence
    a_eth_write: assert property (wr_acc && PADDR_IN == ETH_SEC_ADDR |=>
        {SEC_CFG_OUT.mac_b_nonsecure, SEC_CFG_OUT.mac_a_nonsecure} == $past(PWDATA_IN[1:0]))
        else $error("ethernet bits not written");
    a_sd_write: assert property (wr_acc && PADDR_IN == SD_SEC_ADDR |=>
        {SEC_CFG_OUT.sd_ctrl_b_nonsecure, SEC_CFG_OUT.sd_ctrl_a_nonsecure} == $past(PWDATA_IN[1:0]))
        else $error("sd bits not written");
    a_usb_write: assert property (wr_acc && PADDR_IN == USB_SEC_ADDR |=>
        {SEC_CFG_OUT.usb_ctrl_b_nonsecure, SEC_CFG_OUT.usb_ctrl_a_nonsecure} == $past(PWDATA_IN[1:0]))
        else $error("usb bits not written");
    a_force_write: assert property (wr_acc && PADDR_IN == APB_FORCE_ADDR |=>
        SEC_CFG_OUT[5:0] == $past(PWDATA_IN[5:0])) else $error("apb force bits not written");
    a_cfg_hold: assert property (!$past(wr_acc) |-> $stable(SEC_CFG_OUT))
        else $error("sideband changed without a write");
    a_lm_force: assert property (LM_REQ_NS_OUT == (LM_REQ_NS_IN |
        {SEC_CFG_OUT.logic_master_b_ns_only, SEC_CFG_OUT.logic_master_a_ns_only}))
        else $error("logic master attribute wrong");
    a_hp_force: assert property (HP_REQ_NS_OUT == (HP_REQ_NS_IN | SEC_CFG_OUT[9:6]))
        else $error("hp port attribute wrong");
    a_gp_secure: assert property ((GP_REQ_PASS_OUT & ~GP_REQ_VALID_IN) == 2'h0 &&
        (GP_REQ_VALID_IN & ~GP_REQ_NS_IN & ~GP_REQ_PASS_OUT) == 2'h0)
        else $error("gp request gating wrong");
    a_go_reject: assert property (go_taken ##0 (GO_REQ_IN.chan >= NUM_CHANNELS ||
        (GO_REQ_IN.cpu_ns && GO_REQ_IN.via_secure_port)) |=> LAUNCH_FAIL_OUT && !FETCH_REQ_OUT)
        else $error("illegal launch not refused");
    a_go_start: assert property (go_taken |=> (LAUNCH_FAIL_OUT ^ FETCH_REQ_OUT) &&
        (!FETCH_REQ_OUT || FETCH_ADDR_OUT == $past(GO_REQ_IN.addr)))
        else $error("launch answer wrong");
    a_fetch_hold: assert property (fetch_wait |=> FETCH_REQ_OUT && $stable(FETCH_ADDR_OUT))
        else $error("fetch request not held");
    a_fetch_step: assert property (FETCH_REQ_OUT && FETCH_ACK_IN ##1 FETCH_REQ_OUT |->
        FETCH_ADDR_OUT == $past(FETCH_ADDR_OUT) + INSN_BYTES) else $error("fetch address step");
    a_abort_fail: assert property (FETCH_REQ_OUT && FETCH_ABORT_IN |=>
        LAUNCH_FAIL_OUT && !FETCH_REQ_OUT) else $error("abort not reported");
    a_boot_ready: assert property ($fell(RST_IN) |-> !GO_READY_OUT ##[1:4] GO_READY_OUT)
        else $error("boot sampling window wrong");
endmodule : security_partition_config_checker

bind security_partition_config security_partition_config_checker #(
    .NUM_CHANNELS(NUM_CHANNELS), .FETCH_WORDS(FETCH_WORDS)) u_checker (
    .REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
    .SEC_CFG_OUT(SEC_CFG_OUT), .LM_REQ_NS_IN(LM_REQ_NS_IN), .LM_REQ_NS_OUT(LM_REQ_NS_OUT),
    .HP_REQ_NS_IN(HP_REQ_NS_IN), .HP_REQ_NS_OUT(HP_REQ_NS_OUT),
    .GP_REQ_VALID_IN(GP_REQ_VALID_IN), .GP_REQ_NS_IN(GP_REQ_NS_IN),
    .GP_REQ_PASS_OUT(GP_REQ_PASS_OUT), .GO_VALID_IN(GO_VALID_IN), .GO_REQ_IN(GO_REQ_IN),
    .GO_READY_OUT(GO_READY_OUT), .LAUNCH_FAIL_OUT(LAUNCH_FAIL_OUT),
    .FETCH_REQ_OUT(FETCH_REQ_OUT), .FETCH_ADDR_OUT(FETCH_ADDR_OUT),
    .FETCH_ACK_IN(FETCH_ACK_IN), .FETCH_ABORT_IN(FETCH_ABORT_IN));

// >>> dv/fetch_responder.sv
`timescale 1ns/1ns
module fetch_responder (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Fetch request
    input wire logic req_in,
    input wire logic [31:0] addr_in,
    // Behaviour controls
    input wire logic [3:0] delay_in,
    input wire logic [3:0] abort_idx_in,
    // Answer
    output logic ack_out,
    output logic abort_out,
    output logic [31:0] data_out
);
    logic [3:0] wait_q;
    logic [3:0] cnt_q;
    logic ack_q;
    logic abort_q;
    logic [31:0] last_q;
    assign ack_out = ack_q && req_in;
    assign abort_out = abort_q && req_in;
    // word is the inverted address
    // Released bus shows the inverse, so a stale copy never matches
    assign data_out = ack_out ? ~addr_in : ~last_q;
    always_ff @(posedge clk_in) begin
        if (ack_out) begin
            last_q <= data_out;
        end
        if (rst_in || !req_in) begin
            wait_q <= 4'h0;
            cnt_q <= 4'h0;
            ack_q <= 1'b0;
            abort_q <= 1'b0;
        end else if (wait_q == delay_in) begin
            ack_q <= (cnt_q != abort_idx_in);
            abort_q <= (cnt_q == abort_idx_in);
            cnt_q <= cnt_q + 4'h1;
            wait_q <= 4'h0;
        end else begin
            ack_q <= 1'b0;
            abort_q <= 1'b0;
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule : fetch_responder

// >>> dv/tb.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb
    import secure_partition_pkg::*;
;
    typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_t;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = '0, pwdata = '0, prdata, f_addr, f_data, c_data, rd;
    logic [1:0] lm_in = '0, gp_v = '0, gp_ns = '0, lm_out, gp_pass;
    logic [3:0] hp_in = '0, dly = '0, ab_idx = 4'hF, hp_out;
    logic gp_a = 1'b0, gp_b = 1'b0, boot_ns = 1'b0, go_v = 1'b0, rd_en = 1'b0;
    logic pready, pslverr, go_rdy, l_ok, l_fail, f_req, f_ns, f_ack, f_abort, err;
    logic [2:0] rd_idx = '0;
    go_req_t go_r = '0;
    sec_cfg_t cfg;
    int num_errors = 0, checks_done = 0;
    row_t rows [9] = '{
        '{ETH_SEC_ADDR, 32'h0000_0003, 32'h0000_0003, 1'b0},
        '{SD_SEC_ADDR, 32'h0000_0002, 32'h0000_0002, 1'b0},
        '{USB_SEC_ADDR, 32'h0000_0001, 32'h0000_0001, 1'b0},
        '{LM_DIS_ADDR, 32'h0000_0002, 32'h0000_0002, 1'b0},
        '{HP_DIS_ADDR, 32'h0000_000A, 32'h0000_000A, 1'b0},
        '{APB_FORCE_ADDR, 32'h0000_0025, 32'h0000_0025, 1'b0},
        '{GP_A_FILT_ADDR, 32'h0000_0000, 32'h0000_0001, 1'b0},
        '{GP_B_FILT_ADDR, 32'h0000_0001, 32'h0000_0000, 1'b0},
        '{32'hF800_0460, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1}};

    always #20 clk = ~clk;

    security_partition_config #(.NUM_CHANNELS(8), .FETCH_WORDS(8)) u_security_partition_config (
        .REF_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PREADY_OUT(pready),
        .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr), .SEC_CFG_OUT(cfg),
        .LM_REQ_NS_IN(lm_in), .LM_REQ_NS_OUT(lm_out), .HP_REQ_NS_IN(hp_in),
        .HP_REQ_NS_OUT(hp_out), .GP_A_NS_PASS_IN(gp_a), .GP_B_NS_PASS_IN(gp_b),
        .GP_REQ_VALID_IN(gp_v), .GP_REQ_NS_IN(gp_ns), .GP_REQ_PASS_OUT(gp_pass),
        .DMA_BOOT_NS_IN(boot_ns), .GO_VALID_IN(go_v), .GO_REQ_IN(go_r),
        .GO_READY_OUT(go_rdy), .LAUNCH_OK_OUT(l_ok), .LAUNCH_FAIL_OUT(l_fail),
        .FETCH_REQ_OUT(f_req), .FETCH_ADDR_OUT(f_addr), .FETCH_NS_OUT(f_ns),
        .FETCH_ACK_IN(f_ack), .FETCH_ABORT_IN(f_abort), .FETCH_DATA_IN(f_data),
        .CACHE_RD_EN_IN(rd_en), .CACHE_RD_IDX_IN(rd_idx), .CACHE_RD_DATA_OUT(c_data));

    fetch_responder u_fetch_responder (.clk_in(clk), .rst_in(rst), .req_in(f_req),
        .addr_in(f_addr), .delay_in(dly), .abort_idx_in(ab_idx), .ack_out(f_ack),
        .abort_out(f_abort), .data_out(f_data));

    task automatic apb(input logic [31:0] a, input logic [31:0] d, input logic w);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    // Result code: 0 refused, 1 completed, 2 aborted
    task automatic go(input go_req_t r, input logic [1:0] res, input logic ns);
        int n;
        n = 0;
        @(posedge clk);
        go_v <= 1'b1; go_r <= r;
        @(posedge clk);
        while (go_rdy !== 1'b1 && n < 50) begin @(posedge clk); n++; end
        go_v <= 1'b0;
        @(posedge clk);
        `CHK({l_fail, f_req}, {res == 2'd0, res != 2'd0})
        if (res != 2'd0) begin
            `CHK({f_addr, f_ns}, {r.addr, ns})
            n = 0;
            while (l_ok !== 1'b1 && l_fail !== 1'b1 && n < 200) begin @(posedge clk); n++; end
            `CHK({l_ok, l_fail}, {res == 2'd1, res == 2'd2})
        end
    endtask : go

    task automatic cache_chk(input logic [2:0] i, input logic [31:0] exp);
        @(posedge clk);
        rd_en <= 1'b1; rd_idx <= i;
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
        `CHK(c_data, exp)
    endtask : cache_chk

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            apb(rows[i].a, 32'h0, 1'b0);
            `CHK(rd, 32'h0)
        end
        `CHK(cfg, CFG_RESET)
        $display("test reset values done");
        gp_a <= 1'b1;
        repeat (4) @(posedge clk);
        foreach (rows[i]) begin
            apb(rows[i].a, rows[i].d, 1'b1);
            apb(rows[i].a, 32'h0, 1'b0);
            `CHK({err, rd}, {rows[i].e, rows[i].q})
        end
        $display("test register rows done");
        lm_in <= 2'b00; hp_in <= 4'b0001; gp_v <= 2'b11; gp_ns <= 2'b11;
        repeat (2) @(posedge clk);
        // Eth 11, sd 10, usb 01, lm 10, hp 1010, force 100101
        `CHK(cfg, 18'h39AA5)
        `CHK({lm_out, hp_out, gp_pass}, {2'b10, 4'b1011, 2'b01})
        gp_ns <= 2'b01;
        repeat (2) @(posedge clk);
        `CHK(gp_pass, 2'b11)
        $display("test sideband done");
        go('{8'h00, 32'h0000_1000, 1'b0, 1'b1, 1'b1}, 2'd0, 1'b0);
        go('{8'h00, 32'h0000_1000, 1'b0, 1'b0, 1'b0}, 2'd0, 1'b0);
        go('{8'h08, 32'h0000_1000, 1'b0, 1'b1, 1'b0}, 2'd0, 1'b0);
        go('{8'h07, 32'h0000_2000, 1'b1, 1'b1, 1'b0}, 2'd1, 1'b1);
        cache_chk(3'd0, ~32'h0000_2000);
        cache_chk(3'd7, ~32'h0000_201C);
        dly <= 4'h2;
        go('{8'h00, 32'h0000_3000, 1'b0, 1'b1, 1'b0}, 2'd1, 1'b0);
        cache_chk(3'd3, ~32'h0000_300C);
        ab_idx <= 4'h3;
        go('{8'h01, 32'h0000_4000, 1'b0, 1'b1, 1'b0}, 2'd2, 1'b0);
        apb(LAUNCH_STAT_ADDR, 32'h0, 1'b0);
        `CHK(rd, 32'h0000_0118)
        apb(LAUNCH_STAT_ADDR, 32'h0000_0018, 1'b1);
        apb(LAUNCH_STAT_ADDR, 32'h0, 1'b0);
        `CHK(rd, 32'h0000_0100)
        $display("test secure launches done");
        ab_idx <= 4'hF; dly <= 4'h0; boot_ns <= 1'b1; rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK(cfg, CFG_RESET)
        go('{8'h00, 32'h0000_5000, 1'b0, 1'b1, 1'b0}, 2'd0, 1'b0);
        go('{8'h02, 32'h0000_6000, 1'b1, 1'b0, 1'b1}, 2'd1, 1'b1);
        cache_chk(3'd5, ~32'h0000_6014);
        $display("test nonsecure launches done");
        test_done();
    end

    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        test_done();
    end
endmodule : tb
